// ===== core/shc_dev.sv
// Notes on behaviour
// - Busy high during init, low after
// - User requests only while busy low
// - User holds command fields during request
// - Busy rises on accepting a request
// - User drops request once busy seen
// - Busy falls when the command completes
// - Identify and erase ignore sector fields
// - Write reads FIFO when data and storage ready
// - Transmit data valid one cycle after read
// - Stop reading on empty or all read
// - Write receive FIFO only below threshold
// - Stop writing within 7 cycles, or done
// - User keeps transfers within reported capacity
// - Identify returns 128 indexed 32-bit words
// - Identify updates capacity before busy falls (here: on the same edge as busy falls)
// - User should identify first after boot
// - Erase starts with code 01 when idle
// - Errors raise flag and show cause
// - Error flag cleared only by reset
// - Code 10 writes, code 11 reads
// - Cause bits: link..PIO setup, bit 5 timeout
// - Timeout disabled while erase runs
//
// Local design decisions: the APB slave port and the register addresses.
module shc_dev #(
  parameter int INIT_CYCLES = shc_pkg::SHC_INIT_CYCLES,
  parameter int ERASE_CYCLES = shc_pkg::SHC_ERASE_CYCLES,
  parameter int TIMEOUT_CYCLES = shc_pkg::SHC_TIMEOUT_CYCLES,
  parameter logic [47:0] CAPACITY = 48'h0000_0100_0000
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  shc_if.dev bus,
  input wire logic stg_ready_i,
  input wire logic [4:0] stg_err_i,
  input wire logic [31:0] stg_rdata_i,
  output logic [31:0] stg_wdata_o,
  output logic stg_wvalid_o
);
  import shc_pkg::*;

  shc_state_t state;
  shc_state_t next_state;
  logic [31:0] cnt;
  logic [54:0] remain;
  logic [47:0] cap_acc;
  logic rd_d;
  logic tmo_hit;

  function automatic logic [31:0] ident_fn(input logic [6:0] idx,
                                          input logic [47:0] cap);
    logic [31:0] w;
    w = {25'h0, idx};
    if (idx == SHC_IDENT_CAP_LO) begin
      w = cap[31:0];
    end else if (idx == SHC_IDENT_CAP_HI) begin
      w = {16'h0, cap[47:32]};
    end
    return w;
  endfunction

  wire in_idle = (state == SHC_ST_IDLE);
  wire new_err = |stg_err_i || tmo_hit;
  wire [31:0] next_cause = bus.error_cause |
                           {26'h0, tmo_hit, stg_err_i};
  wire accept = in_idle && bus.cmd_request;
  wire left = (remain != 55'h0);
  // Read only every other cycle so a late empty cannot underrun
  wire next_rd = (state == SHC_ST_WRITE) && left && !bus.tx_fifo_empty
                 && stg_ready_i && !bus.tx_fifo_read;
  wire room = (bus.rx_fifo_fill < SHC_RX_THRESH);
  wire next_wr = (state == SHC_ST_READ) && left && stg_ready_i
                 && room;
  wire cnt_last_init = (cnt == 32'(INIT_CYCLES - 1));
  wire cnt_last_erase = (cnt == 32'(ERASE_CYCLES - 1));
  wire cnt_last_ident = (cnt == 32'(SHC_IDENT_WORDS - 1));
  wire wr_done = !left && !bus.tx_fifo_read && !rd_d;
  wire [54:0] words = {bus.sector_count, 7'h0};
  wire tmo_en = !in_idle && (state != SHC_ST_ERASE);

  shc_tmo #(
    .LIMIT(TIMEOUT_CYCLES)
  ) u_tmo (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .enable_i(tmo_en),
    .kick_i(stg_ready_i),
    .expired_o(tmo_hit)
  );

  always_comb begin
    next_state = state;
    case (state)
      SHC_ST_INIT: begin
        if (cnt_last_init) next_state = SHC_ST_IDLE;
      end
      SHC_ST_IDLE: begin
        if (bus.cmd_request) begin
          case (shc_cmd_t'(bus.cmd_code))
            SHC_CMD_IDENT: next_state = SHC_ST_IDENT;
            SHC_CMD_ERASE: next_state = SHC_ST_ERASE;
            SHC_CMD_WRITE: next_state = SHC_ST_WRITE;
            default: next_state = SHC_ST_READ;
          endcase
        end
      end
      SHC_ST_IDENT: begin
        if (cnt_last_ident) next_state = SHC_ST_IDLE;
      end
      SHC_ST_ERASE: begin
        if (cnt_last_erase) next_state = SHC_ST_IDLE;
      end
      SHC_ST_WRITE: begin
        if (wr_done) next_state = SHC_ST_IDLE;
      end
      SHC_ST_READ: begin
        if (!left) next_state = SHC_ST_IDLE;
      end
      default: next_state = SHC_ST_IDLE;
    endcase
    // Any fault aborts the running job back to idle
    if (new_err && !in_idle) next_state = SHC_ST_IDLE;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= SHC_ST_INIT;
      bus.core_busy <= 1'b1;
    end else begin
      state <= next_state;
      // Busy follows the state, so it rises on accept and falls on done
      bus.core_busy <= (next_state != SHC_ST_IDLE);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt <= 32'h0;
    end else if (state != next_state) begin
      cnt <= 32'h0;
    end else begin
      cnt <= cnt + 32'h1;
    end
  end

  // Sector fields only matter for transfers
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      remain <= 55'h0;
    end else if (accept) begin
      remain <= bus.cmd_code[1] ? words : 55'h0;
    end else if (next_rd || next_wr) begin
      remain <= remain - 55'h1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus.tx_fifo_read <= 1'b0;
      rd_d <= 1'b0;
      stg_wvalid_o <= 1'b0;
      stg_wdata_o <= 32'h0;
    end else begin
      bus.tx_fifo_read <= next_rd;
      rd_d <= bus.tx_fifo_read;
      stg_wvalid_o <= rd_d;
      stg_wdata_o <= rd_d ? bus.tx_fifo_rdata : stg_wdata_o;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus.rx_fifo_write <= 1'b0;
      bus.rx_fifo_wdata <= 32'h0;
    end else begin
      bus.rx_fifo_write <= next_wr;
      bus.rx_fifo_wdata <= next_wr ? stg_rdata_i : bus.rx_fifo_wdata;
    end
  end

  wire ident_emit = (state == SHC_ST_IDENT) && !new_err;
  wire [31:0] ident_now = ident_fn(cnt[6:0], CAPACITY);

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus.ident_word_valid <= 1'b0;
      bus.ident_word_index <= 7'h0;
      bus.ident_word <= 32'h0;
    end else begin
      bus.ident_word_valid <= ident_emit;
      bus.ident_word_index <= cnt[6:0];
      bus.ident_word <= ident_now;
    end
  end

  // Capacity is built from the words as they go out
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cap_acc <= SHC_CAP_RESET;
      bus.device_capacity <= SHC_CAP_RESET;
    end else begin
      if (ident_emit && cnt[6:0] == SHC_IDENT_CAP_LO) begin
        cap_acc[31:0] <= ident_now;
      end
      if (ident_emit && cnt[6:0] == SHC_IDENT_CAP_HI) begin
        cap_acc[47:32] <= ident_now[15:0];
      end
      if (ident_emit && cnt_last_ident) begin
        bus.device_capacity <= cap_acc;
      end
    end
  end

  // Sticky; only the reset clears cause and flag
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus.error_cause <= 32'h0;
      bus.error_flag <= 1'b0;
    end else begin
      bus.error_cause <= next_cause;
      bus.error_flag <= |next_cause;
    end
  end
endmodule

// ===== pkg/shc_pkg.sv
package shc_pkg;
  typedef enum logic [1:0] {
    SHC_CMD_IDENT = 2'h0,
    SHC_CMD_ERASE = 2'h1,
    SHC_CMD_WRITE = 2'h2,
    SHC_CMD_READ = 2'h3
  } shc_cmd_t;

  typedef enum logic [5:0] {
    SHC_ST_INIT = 6'h01,
    SHC_ST_IDLE = 6'h02,
    SHC_ST_IDENT = 6'h04,
    SHC_ST_ERASE = 6'h08,
    SHC_ST_WRITE = 6'h10,
    SHC_ST_READ = 6'h20
  } shc_state_t;

  localparam int SHC_CLK_PERIOD_NS = 20;
  localparam int SHC_INIT_TIME_NS = 2000;
  localparam int SHC_INIT_CYCLES =
    (SHC_INIT_TIME_NS + SHC_CLK_PERIOD_NS - 1) / SHC_CLK_PERIOD_NS;
  localparam int SHC_ERASE_CYCLES = 64;
  localparam int SHC_TIMEOUT_CYCLES = 1000000;

  localparam int SHC_SECTOR_W = 48;
  localparam int SHC_WORD_SHIFT = 7;
  localparam int SHC_IDENT_WORDS = 128;
  localparam logic [6:0] SHC_IDENT_CAP_LO = 7'h32;
  localparam logic [6:0] SHC_IDENT_CAP_HI = 7'h33;
  localparam logic [15:0] SHC_RX_THRESH = 16'hFFF8;
  localparam logic [47:0] SHC_CAP_RESET = 48'h0;

  localparam int SHC_CAUSE_LINK = 0;
  localparam int SHC_CAUSE_DATA = 1;
  localparam int SHC_CAUSE_STAT = 2;
  localparam int SHC_CAUSE_DMA = 3;
  localparam int SHC_CAUSE_PIO = 4;
  localparam int SHC_CAUSE_TMO = 5;

  localparam logic [7:0] SHC_REG_CTRL = 8'h00;
  localparam logic [7:0] SHC_REG_ADDR_LO = 8'h04;
  localparam logic [7:0] SHC_REG_ADDR_HI = 8'h08;
  localparam logic [7:0] SHC_REG_LEN_LO = 8'h0C;
  localparam logic [7:0] SHC_REG_LEN_HI = 8'h10;
  localparam logic [7:0] SHC_REG_STATUS = 8'h14;
  localparam logic [7:0] SHC_REG_CAUSE = 8'h18;
  localparam logic [7:0] SHC_REG_CAP_LO = 8'h1C;
  localparam logic [7:0] SHC_REG_CAP_HI = 8'h20;
  localparam logic [7:0] SHC_REG_IDENT_CNT = 8'h24;
  localparam int SHC_CTRL_GO = 31;
  localparam int SHC_STAT_BUSY = 0;
  localparam int SHC_STAT_ERR = 1;
  localparam int SHC_STAT_PEND = 2;
endpackage

// ===== pkg/shc_if.sv
interface shc_if;
  logic cmd_request;
  logic [1:0] cmd_code;
  logic [47:0] start_sector;
  logic [47:0] sector_count;
  logic core_busy;
  logic [47:0] device_capacity;
  logic error_flag;
  logic [31:0] error_cause;
  logic tx_fifo_empty;
  logic tx_fifo_read;
  logic [31:0] tx_fifo_rdata;
  logic [15:0] rx_fifo_fill;
  logic rx_fifo_write;
  logic [31:0] rx_fifo_wdata;
  logic ident_word_valid;
  logic [6:0] ident_word_index;
  logic [31:0] ident_word;

  modport dev (
    input cmd_request, cmd_code, start_sector, sector_count,
    input tx_fifo_empty, tx_fifo_rdata, rx_fifo_fill,
    output core_busy, device_capacity, error_flag, error_cause,
    output tx_fifo_read, rx_fifo_write, rx_fifo_wdata,
    output ident_word_valid, ident_word_index, ident_word
  );
  modport host (
    output cmd_request, cmd_code, start_sector, sector_count,
    output tx_fifo_empty, tx_fifo_rdata, rx_fifo_fill,
    input core_busy, device_capacity, error_flag, error_cause,
    input tx_fifo_read, rx_fifo_write, rx_fifo_wdata,
    input ident_word_valid, ident_word_index, ident_word
  );
endinterface

// ===== core/shc_tmo.sv
module shc_tmo #(
  parameter int LIMIT = 1000000
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic enable_i,
  input wire logic kick_i,
  output logic expired_o
);
  import shc_pkg::*;

  logic [31:0] count;
  wire at_limit = (count == 32'(LIMIT - 1));

  // Count only idle waiting; any progress or disable restarts it
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count <= 32'h0;
      expired_o <= 1'b0;
    end else begin
      expired_o <= enable_i && !kick_i && at_limit;
      if (!enable_i || kick_i || at_limit) begin
        count <= 32'h0;
      end else begin
        count <= count + 32'h1;
      end
    end
  end
endmodule

// ===== core/shc_host.sv
module shc_host (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  shc_if.host bus,
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic usr_tx_empty_i,
  input wire logic [31:0] usr_tx_data_i,
  output logic usr_tx_pop_o,
  input wire logic [15:0] usr_rx_fill_i,
  output logic usr_rx_push_o,
  output logic [31:0] usr_rx_data_o
);
  import shc_pkg::*;

  logic [1:0] code;
  logic [47:0] addr;
  logic [47:0] len;
  logic pend;
  logic [7:0] ident_cnt;

  // FIFO pins pass straight through to keep the one-cycle read latency
  assign bus.tx_fifo_empty = usr_tx_empty_i;
  assign bus.tx_fifo_rdata = usr_tx_data_i;
  assign bus.rx_fifo_fill = usr_rx_fill_i;
  assign usr_tx_pop_o = bus.tx_fifo_read;
  assign usr_rx_push_o = bus.rx_fifo_write;
  assign usr_rx_data_o = bus.rx_fifo_wdata;
  assign bus.cmd_code = code;
  assign bus.start_sector = addr;
  assign bus.sector_count = len;

  wire setup = psel_i && !penable_i;
  wire acc = psel_i && penable_i && pready_o;
  wire wr = acc && pwrite_i;
  wire hit_ctrl = (paddr_i == SHC_REG_CTRL);
  wire hit_alo = (paddr_i == SHC_REG_ADDR_LO);
  wire hit_ahi = (paddr_i == SHC_REG_ADDR_HI);
  wire hit_llo = (paddr_i == SHC_REG_LEN_LO);
  wire hit_lhi = (paddr_i == SHC_REG_LEN_HI);
  wire hit_stat = (paddr_i == SHC_REG_STATUS);
  wire hit_cause = (paddr_i == SHC_REG_CAUSE);
  wire hit_clo = (paddr_i == SHC_REG_CAP_LO);
  wire hit_chi = (paddr_i == SHC_REG_CAP_HI);
  wire hit_icnt = (paddr_i == SHC_REG_IDENT_CNT);
  wire hit_any = hit_ctrl || hit_alo || hit_ahi || hit_llo || hit_lhi ||
                 hit_stat || hit_cause || hit_clo || hit_chi || hit_icnt;
  // Fields frozen while a request is pending or raised
  wire locked = pend || bus.cmd_request;
  wire go = wr && hit_ctrl && pwdata_i[SHC_CTRL_GO];

  wire [31:0] rd_mux =
    hit_ctrl ? {30'h0, code} :
    hit_alo ? addr[31:0] :
    hit_ahi ? {16'h0, addr[47:32]} :
    hit_llo ? len[31:0] :
    hit_lhi ? {16'h0, len[47:32]} :
    hit_stat ? {29'h0, pend, bus.error_flag, bus.core_busy} :
    hit_cause ? bus.error_cause :
    hit_clo ? bus.device_capacity[31:0] :
    hit_chi ? {16'h0, bus.device_capacity[47:32]} :
    hit_icnt ? {24'h0, ident_cnt} : 32'h0;

  // Answer prepared in setup, so the access phase still has no wait state
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0;
    end else begin
      pready_o <= setup;
      pslverr_o <= setup && !hit_any;
      prdata_o <= setup ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      code <= 2'h0;
      addr <= 48'h0;
      len <= 48'h0;
    end else if (wr && !locked) begin
      if (hit_ctrl) code <= pwdata_i[1:0];
      if (hit_alo) addr[31:0] <= pwdata_i;
      if (hit_ahi) addr[47:32] <= pwdata_i[15:0];
      if (hit_llo) len[31:0] <= pwdata_i;
      if (hit_lhi) len[47:32] <= pwdata_i[15:0];
    end
  end

  // A go while busy is kept pending until the device is idle
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pend <= 1'b0;
      bus.cmd_request <= 1'b0;
    end else begin
      if (bus.cmd_request && bus.core_busy) begin
        bus.cmd_request <= 1'b0;
      end else if (pend && !bus.core_busy && !bus.cmd_request) begin
        bus.cmd_request <= 1'b1;
      end
      if (go && !locked) begin
        pend <= 1'b1;
      end else if (pend && !bus.core_busy && !bus.cmd_request) begin
        pend <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ident_cnt <= 8'h0;
    end else if (bus.cmd_request && !bus.core_busy) begin
      ident_cnt <= 8'h0;
    end else if (bus.ident_word_valid) begin
      ident_cnt <= ident_cnt + 8'h1;
    end
  end
endmodule

// ===== verif/shc_sva.sv
module shc_sva #(
  parameter int ERASE_CYCLES = shc_pkg::SHC_ERASE_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic cmd_request,
  input wire logic [1:0] cmd_code,
  input wire logic core_busy,
  input wire logic [47:0] device_capacity,
  input wire logic error_flag,
  input wire logic [31:0] error_cause,
  input wire logic tx_fifo_empty,
  input wire logic tx_fifo_read,
  input wire logic [15:0] rx_fifo_fill,
  input wire logic rx_fifo_write,
  input wire logic ident_word_valid,
  input wire logic [6:0] ident_word_index
);
  import shc_pkg::*;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  wire take = !core_busy && cmd_request;
  logic ers_on;
  logic [31:0] ers_n;

  // Erase outlasts any repetition count, so its busy cycles are counted
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ers_on <= 1'b0;
      ers_n <= 32'h0;
    end else if (take && cmd_code == SHC_CMD_ERASE) begin
      ers_on <= 1'b1;
      ers_n <= 32'h0;
    end else if (ers_on && core_busy) begin
      ers_n <= ers_n + 32'h1;
    end else begin
      ers_on <= 1'b0;
    end
  end

  chk_busy_init: assert property (
    $rose(rst_b_i) |-> core_busy[*3] ##[1:8] !core_busy)
    else $error("busy wrong around init");
  chk_busy_accept: assert property (
    take |=> core_busy)
    else $error("busy did not rise on request");
  chk_erase_len: assert property (
    ers_on && !core_busy |-> ers_n == 32'(ERASE_CYCLES))
    else $error("erase busy length wrong");
  chk_ident_first: assert property (
    take && cmd_code == SHC_CMD_IDENT |->
      ##2 (ident_word_valid && ident_word_index == 7'h0))
    else $error("identify did not start at word 0");
  chk_ident_next: assert property (
    ident_word_valid && ident_word_index != 7'h7F |=>
      ident_word_valid &&
      ident_word_index == $past(ident_word_index) + 7'h1)
    else $error("identify index not consecutive");
  chk_tx_empty: assert property (
    tx_fifo_read |-> $past(tx_fifo_empty) == 1'b0)
    else $error("transmit read while empty");
  chk_rx_stop: assert property (
    (rx_fifo_fill >= SHC_RX_THRESH)[*7] |-> !rx_fifo_write)
    else $error("receive write not stopped");
  chk_err_flag: assert property (
    error_cause != 32'h0 |-> error_flag)
    else $error("cause set without flag");
  chk_err_idle: assert property (
    $rose(error_flag) |-> ##[0:1] !core_busy)
    else $error("busy held after error");
  chk_err_sticky: assert property (
    error_flag |=> error_flag &&
      (error_cause & $past(error_cause)) == $past(error_cause))
    else $error("error state cleared");
  chk_cap_busy: assert property (
    $changed(device_capacity) |-> $fell(core_busy))
    else $error("capacity changed outside completion");

  cover property (ident_word_valid && ident_word_index == 7'h7F);
  cover property (tx_fifo_read);
  cover property (rx_fifo_write);
  cover property ($rose(error_flag));
endmodule

// ===== verif/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import shc_pkg::*;
  localparam logic [47:0] CAP = 48'h0000_0100_0000;
  // Erase longer than the timeout, to show the timeout is off during it
  localparam int ERS = 80;
  logic clk = 1'b0;
  logic rst_b, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, tx_data, rx_data, stg_rd, stg_wd, prev_rd;
  logic tx_empty, tx_pop, rx_push, stg_rdy, stg_wv, rdy_en, fill_hi;
  logic [15:0] rx_fill;
  logic [4:0] stg_err;
  logic [31:0] txq[$], txexp[$], gotw[$];
  int err_count = 0;
  int n_checks = 0;
  int idn, nrx;

  always #10 clk = ~clk;

  shc_if u_if();
  shc_dev #(.INIT_CYCLES(4), .ERASE_CYCLES(ERS), .TIMEOUT_CYCLES(50),
    .CAPACITY(CAP)) shc_dev_inst (.core_clk_i(clk), .rst_b_i(rst_b),
    .bus(u_if), .stg_ready_i(stg_rdy), .stg_err_i(stg_err),
    .stg_rdata_i(stg_rd), .stg_wdata_o(stg_wd), .stg_wvalid_o(stg_wv));
  shc_host shc_host_inst (.core_clk_i(clk), .rst_b_i(rst_b), .bus(u_if),
    .paddr_i(paddr), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .usr_tx_empty_i(tx_empty), .usr_tx_data_i(tx_data),
    .usr_tx_pop_o(tx_pop), .usr_rx_fill_i(rx_fill),
    .usr_rx_push_o(rx_push), .usr_rx_data_o(rx_data));
  shc_sva #(.ERASE_CYCLES(ERS)) shc_sva_inst (.core_clk_i(clk),
    .rst_b_i(rst_b),
    .cmd_request(u_if.cmd_request), .cmd_code(u_if.cmd_code),
    .core_busy(u_if.core_busy), .device_capacity(u_if.device_capacity),
    .error_flag(u_if.error_flag), .error_cause(u_if.error_cause),
    .tx_fifo_empty(u_if.tx_fifo_empty), .tx_fifo_read(u_if.tx_fifo_read),
    .rx_fifo_fill(u_if.rx_fifo_fill), .rx_fifo_write(u_if.rx_fifo_write),
    .ident_word_valid(u_if.ident_word_valid),
    .ident_word_index(u_if.ident_word_index));

  task end_of_test;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task cmp(input string nm, input logic [47:0] e, input logic [47:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task wait_busy(input logic v);
    int n;
    n = 0;
    @(negedge clk);
    while (u_if.core_busy !== v && n < 3000) begin
      @(negedge clk);
      n++;
    end
    cmp("busy level", v, u_if.core_busy);
  endtask

  task run(input logic [1:0] c, input logic [47:0] a, input logic [47:0] l);
    wr(SHC_REG_ADDR_LO, a[31:0]);
    wr(SHC_REG_ADDR_HI, {16'h0, a[47:32]});
    wr(SHC_REG_LEN_LO, l[31:0]);
    wr(SHC_REG_LEN_HI, {16'h0, l[47:32]});
    wr(SHC_REG_CTRL, {1'b1, 29'h0, c});
    wait_busy(1'b1);
    wait_busy(1'b0);
  endtask

  function automatic logic [31:0] ident_exp(input int i);
    if (i == 50)
      return CAP[31:0];
    if (i == 51)
      return {16'h0, CAP[47:32]};
    return i;
  endfunction

  // Far-side FIFOs and storage; tx data lands the cycle after a pop
  always @(posedge clk) begin
    stg_rdy <= rdy_en & ($urandom % 4 != 0);
    stg_rd <= $urandom;
    prev_rd <= stg_rd;
    rx_fill <= fill_hi ? 16'hFFF8 + 16'($urandom % 8) :
      16'($urandom % 16'hFFF0);
    if (tx_pop && txq.size() > 0)
      tx_data <= txq.pop_front();
    tx_empty <= (txq.size() == 0) || ($urandom % 3 == 0);
    if (stg_wv)
      gotw.push_back(stg_wd);
    if (u_if.ident_word_valid) begin
      cmp("ident index", idn, u_if.ident_word_index);
      cmp("ident word", ident_exp(idn), u_if.ident_word);
      idn++;
    end
    if (rx_push) begin
      cmp("rx data", prev_rd, rx_data);
      nrx++;
    end
  end

  initial begin
    #800000;
    err_count++;
    end_of_test();
  end

  initial begin
    logic [31:0] r, w;
    logic e;
    void'($urandom(75861));
    {rst_b, psel, penable, pwrite, paddr, pwdata, stg_err} = '0;
    {tx_data, tx_empty, stg_rdy, stg_rd, prev_rd, rx_fill} = '0;
    {rdy_en, fill_hi, idn, nrx} = {2'b10, 64'h0};
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    cmp("busy in init", 1'b1, u_if.core_busy);
    wait_busy(1'b0);
    cmp("capacity reset", 48'h0, u_if.device_capacity);
    apb(1'b0, 8'h28, 32'h0, r, e);
    cmp("unmapped error", 1'b1, e);
    cmp("unmapped data", 32'h0, r);
    run(SHC_CMD_IDENT, {16'($urandom), $urandom}, 48'($urandom));
    // Last word is seen one edge after busy falls
    @(negedge clk);
    cmp("ident words", 128, idn);
    apb(1'b0, SHC_REG_IDENT_CNT, 32'h0, r, e);
    cmp("ident count", 128, r);
    cmp("capacity", CAP, u_if.device_capacity);
    apb(1'b0, SHC_REG_CAP_LO, 32'h0, r, e);
    cmp("capacity reg", CAP[31:0], r);
    rdy_en = 1'b0;
    run(SHC_CMD_ERASE, 48'($urandom), 48'($urandom));
    cmp("erase no error", 1'b0, u_if.error_flag);
    rdy_en = 1'b1;
    for (int i = 0; i < 128; i++) begin
      w = $urandom;
      txq.push_back(w);
      txexp.push_back(w);
    end
    run(SHC_CMD_WRITE, 48'h10, 48'h1);
    repeat (4) @(negedge clk);
    cmp("write words", 128, gotw.size());
    foreach (txexp[i])
      cmp("write data", txexp[i], gotw[i]);
    fork
      run(SHC_CMD_READ, 48'h20, 48'h1);
      begin
        repeat (40) @(negedge clk);
        fill_hi = 1'b1;
        repeat (12) @(negedge clk);
        fill_hi = 1'b0;
      end
    join
    cmp("read words", 128, nrx);
    // Empty tx FIFO keeps the write running until the fault hits
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      wait_busy(1'b0);
      // Reset drops the capacity, so identify again before writing
      idn = 0;
      run(SHC_CMD_IDENT, 48'h0, 48'h0);
      rdy_en = (i != 5);
      fork
        run(SHC_CMD_WRITE, 48'h0, 48'h2);
        if (i < 5) begin
          repeat (25) @(posedge clk);
          stg_err <= 5'(1 << i);
          @(posedge clk);
          stg_err <= 5'h0;
        end
      join
      cmp("error cause", 32'h1 << i, u_if.error_cause);
      cmp("error flag", 1'b1, u_if.error_flag);
      repeat (5) @(negedge clk);
      apb(1'b0, SHC_REG_STATUS, 32'h0, r, e);
      cmp("status", 32'h2, r & 32'h3);
      apb(1'b0, SHC_REG_CAUSE, 32'h0, r, e);
      cmp("cause reg", 32'h1 << i, r);
    end
    rdy_en = 1'b1;
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    cmp("error cleared", 1'b0, u_if.error_flag);
    wait_busy(1'b0);
    end_of_test();
  end
endmodule
